// file: core/lcd_frame_divider.sv
// lcd clock divider: crystal rate from core clock, then 2^9..2^6 division
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cfg.svh"

module lcd_frame_divider
    import lcd_pkg::*;
#(
    parameter int CORE_HZ = `LCD_CORE_HZ
) (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       ce_in,
    input  wire logic [1:0] clk_sel_in,
    output var  logic       tick_out
);

    // core rate must stay above the crystal rate for one tick per period
    localparam logic [`LCD_ACC_W-1:0] CORE_STEP = `LCD_ACC_W'(CORE_HZ);
    localparam logic [`LCD_ACC_W-1:0] XTAL_HZ = `LCD_ACC_W'(`LCD_XTAL_HZ);
    localparam int DW = `LCD_DIV_LOG2_MAX;

    logic [`LCD_ACC_W-1:0] acc_reg;
    logic [`LCD_ACC_W-1:0] acc_sum;
    logic                  xtal_tick;
    logic [DW-1:0]         div_reg;
    logic [DW-1:0]         div_mask;
    logic                  frame_hit;

    // phase accumulator makes one crystal-rate tick per 32768 Hz period
    assign acc_sum   = acc_reg + XTAL_HZ;
    assign xtal_tick = (acc_sum >= CORE_STEP);
    // code 00 keeps 9 bits (2^9), code 11 keeps 6 bits (2^6)
    assign div_mask  = {DW{1'b1}} >> clk_sel_in;
    assign frame_hit = xtal_tick && ((div_reg & div_mask) == div_mask);

    // crystal accumulator
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            acc_reg <= '0;
        end else if (ce_in) begin
            acc_reg <= xtal_tick ? acc_sum - CORE_STEP : acc_sum;
        end
    end

    // binary divider of the crystal ticks
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            div_reg <= '0;
        end else if (ce_in && xtal_tick) begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // registered lcd clock pulse
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            tick_out <= 1'b0;
        end else if (ce_in) begin
            tick_out <= frame_hit;
        end
    end

    // pulse only after the selected number of crystal ticks
    AST_DIV_TICK: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ce_in && !frame_hit |=> !tick_out)
        else $error("lcd clock pulse without divider terminal count");

endmodule
`default_nettype wire

// file: core/segment_lcd_control.sv
// control and configuration of the multiplexed segment lcd driver
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cfg.svh"

module segment_lcd_control
    import lcd_pkg::*;
#(
    parameter int         CORE_HZ      = `LCD_CORE_HZ,
    parameter int         NUM_PINS     = `LCD_NUM_PINS,
    parameter int         NUM_COM      = `LCD_NUM_COM,
    parameter int         BLINK_FRAMES = `LCD_BLINK_FRAMES,
    parameter logic [7:0] INPUT_ONLY   = 8'he0
) (
    input  wire logic                  CORE_CLK_IN,
    input  wire logic                  RSTN_IN,
    input  wire logic                  CE_IN,
    input  wire bus_req_t              BUS_REQ_IN,
    output var  logic [7:0]            RDATA_OUT,
    output var  logic                  FRAME_TICK_OUT,
    output var  logic [2:0]            COM_INDEX_OUT,
    output var  logic                  BIAS_GROUND_OUT,
    output var  logic [NUM_PINS-1:0]   PIN_LCD_EN_OUT,
    output var  logic [NUM_PINS-1:0]   PIN_AS_COM_OUT,
    output var  logic [NUM_PINS-1:0]   PIN_GROUND_OUT,
    output var  logic [NUM_PINS-1:0]   PIN_PULLUP_OUT,
    output var  logic                  BAT_SUPPLY_OUT,
    output var  logic [4:0]            CONTRAST_OUT,
    output var  logic [2:0]            MODE_OUT,
    output var  logic                  BLANK23_OUT,
    output var  logic                  BLANK22_OUT
);

    localparam logic [2:0] LAST_COM   = 3'(NUM_COM - 1);
    localparam logic [7:0] LAST_FRAME = 8'(BLINK_FRAMES - 1);

    // register state
    ctrl_t        ctrl_reg;
    logic [5:0]   blink23_reg;
    logic [5:0]   blink22_reg;
    logic         bat_reg;
    logic [7:0]   pinmap_reg;
    logic [4:0]   contrast_reg;

    // sequencing state
    logic         lcd_tick;
    logic [2:0]   com_reg;
    logic [7:0]   frame_cnt_reg;
    blink_state_t blink_reg;
    logic         frame_end;

    // bus decode
    logic         wr_ctrl;
    logic         wr_b23;
    logic         wr_b22;
    logic         wr_map;
    logic         wr_con;
    logic [7:0]   rdata_next;

    assign wr_ctrl = BUS_REQ_IN.wr && (BUS_REQ_IN.addr == `LCD_CTRL_ADDR);
    assign wr_b23  = BUS_REQ_IN.wr && (BUS_REQ_IN.addr == `LCD_BLINK23_ADDR);
    assign wr_b22  = BUS_REQ_IN.wr && (BUS_REQ_IN.addr == `LCD_BLINK22_ADDR);
    assign wr_map  = BUS_REQ_IN.wr && (BUS_REQ_IN.addr == `LCD_PINMAP_ADDR);
    assign wr_con  = BUS_REQ_IN.wr && (BUS_REQ_IN.addr == `LCD_CONTRAST_ADDR);

    // control register, reserved bit kept zero
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RSTN_IN) begin
            ctrl_reg <= ctrl_t'(`LCD_CTRL_RST);
        end else if (CE_IN && wr_ctrl) begin
            ctrl_reg     <= ctrl_t'(BUS_REQ_IN.wdata);
            ctrl_reg.rsv <= 1'b0;
        end
    end

    // blink masks and battery select
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RSTN_IN) begin
            blink23_reg <= `LCD_BLINK_RST;
            blink22_reg <= `LCD_BLINK_RST;
            bat_reg     <= 1'b0;
        end else if (CE_IN) begin
            if (wr_b23) begin
                blink23_reg <= BUS_REQ_IN.wdata[`LCD_BLINK_MSB:0];
            end
            if (wr_b22) begin
                blink22_reg <= BUS_REQ_IN.wdata[`LCD_BLINK_MSB:0];
                bat_reg     <= BUS_REQ_IN.wdata[`BATTERY_SUPPLY_SELECT_BIT];
            end
        end
    end

    // pin map and contrast code
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RSTN_IN) begin
            pinmap_reg   <= `LCD_PINMAP_RST;
            contrast_reg <= `LCD_CONTRAST_RST;
        end else if (CE_IN) begin
            if (wr_map) begin
                pinmap_reg <= BUS_REQ_IN.wdata;
            end
            if (wr_con) begin
                contrast_reg <= BUS_REQ_IN.wdata[`LCD_CONTRAST_MSB:0];
            end
        end
    end

    // read mux, unmapped and reserved bits read zero
    always_comb begin
        rdata_next = 8'h00;
        if (BUS_REQ_IN.rd) begin
            case (BUS_REQ_IN.addr)
                `LCD_CTRL_ADDR:     rdata_next = ctrl_reg;
                `LCD_BLINK23_ADDR:  rdata_next = {2'h0, blink23_reg};
                `LCD_BLINK22_ADDR:  rdata_next = {bat_reg, 1'b0, blink22_reg};
                `LCD_PINMAP_ADDR:   rdata_next = pinmap_reg;
                `LCD_CONTRAST_ADDR: rdata_next = {3'h0, contrast_reg};
                default:            rdata_next = 8'h00;
            endcase
        end
    end

    // read data valid the cycle after the strobe only
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RSTN_IN) begin
            RDATA_OUT <= 8'h00;
        end else if (CE_IN) begin
            RDATA_OUT <= rdata_next;
        end
    end

    // lcd clock from the crystal divider
    lcd_frame_divider #(.CORE_HZ(CORE_HZ)) u_div (
        .clk_in     (CORE_CLK_IN),
        .rstn_in    (RSTN_IN),
        .ce_in      (CE_IN),
        .clk_sel_in (ctrl_reg.clk_sel),
        .tick_out   (lcd_tick)
    );

    assign frame_end = lcd_tick && (com_reg == LAST_COM);

    // common phase walks 0..NUM_COM-1 per lcd clock, parked when off
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RSTN_IN) begin
            com_reg <= 3'h0;
        end else if (CE_IN) begin
            if (!ctrl_reg.enable) begin
                com_reg <= 3'h0;
            end else if (lcd_tick) begin
                com_reg <= (com_reg == LAST_COM) ? 3'h0 : com_reg + 3'h1;
            end
        end
    end

    // blink state toggles every BLINK_FRAMES whole frames
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RSTN_IN) begin
            frame_cnt_reg <= 8'h00;
            blink_reg     <= BLINK_SHOW;
        end else if (CE_IN) begin
            if (!ctrl_reg.enable) begin
                frame_cnt_reg <= 8'h00;
                blink_reg     <= BLINK_SHOW;
            end else if (frame_end) begin
                if (frame_cnt_reg == LAST_FRAME) begin
                    frame_cnt_reg <= 8'h00;
                    case (blink_reg)
                        BLINK_SHOW: blink_reg <= BLINK_HIDE;
                        BLINK_HIDE: blink_reg <= BLINK_SHOW;
                        default:    blink_reg <= BLINK_SHOW;
                    endcase
                end else begin
                    frame_cnt_reg <= frame_cnt_reg + 8'h01;
                end
            end
        end
    end

    // per-pin drive roles
    generate
        for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
            always_ff @(posedge CORE_CLK_IN) begin
                if (!RSTN_IN) begin
                    PIN_LCD_EN_OUT[p] <= 1'b0;
                    PIN_AS_COM_OUT[p] <= 1'b0;
                    PIN_GROUND_OUT[p] <= 1'b0;
                    PIN_PULLUP_OUT[p] <= 1'b0;
                end else if (CE_IN) begin
                    PIN_LCD_EN_OUT[p] <= pinmap_reg[p];
                    PIN_AS_COM_OUT[p] <= pinmap_reg[p] && ctrl_reg.all_com;
                    PIN_GROUND_OUT[p] <= pinmap_reg[p] && !ctrl_reg.enable;
                    PIN_PULLUP_OUT[p] <= !pinmap_reg[p] && INPUT_ONLY[p];
                end
            end
        end
    endgenerate

    // supply, contrast, bias and timing outputs
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RSTN_IN) begin
            BIAS_GROUND_OUT <= 1'b0;
            BAT_SUPPLY_OUT  <= 1'b0;
            CONTRAST_OUT    <= 5'h00;
            MODE_OUT        <= 3'h0;
            FRAME_TICK_OUT  <= 1'b0;
            COM_INDEX_OUT   <= 3'h0;
        end else if (CE_IN) begin
            BIAS_GROUND_OUT <= !ctrl_reg.enable;
            BAT_SUPPLY_OUT  <= bat_reg;
            CONTRAST_OUT    <= contrast_reg;
            MODE_OUT        <= ctrl_reg.mode;
            FRAME_TICK_OUT  <= lcd_tick && ctrl_reg.enable;
            COM_INDEX_OUT   <= com_reg;
        end
    end

    // blanking of pins 23 and 22 in the hidden blink phase
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RSTN_IN) begin
            BLANK23_OUT <= 1'b0;
            BLANK22_OUT <= 1'b0;
        end else if (CE_IN) begin
            BLANK23_OUT <= (blink_reg == BLINK_HIDE) && blink23_reg[com_reg];
            BLANK22_OUT <= (blink_reg == BLINK_HIDE) && blink22_reg[com_reg];
        end
    end

    // checks
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    sequence s_frame_wrap;
        CE_IN && ctrl_reg.enable && frame_end;
    endsequence

    sequence s_disabled;
        CE_IN && !ctrl_reg.enable;
    endsequence

    AST_BIAS_GND: assert property (CE_IN && !ctrl_reg.enable |=> BIAS_GROUND_OUT)
        else $error("bias nodes not grounded while disabled");

    AST_PIN_GND: assert property (CE_IN |=>
        PIN_GROUND_OUT == ($past(pinmap_reg) & {NUM_PINS{!$past(ctrl_reg.enable)}}))
        else $error("mapped pin grounding wrong");

    AST_ALLCOM: assert property (CE_IN |=>
        PIN_AS_COM_OUT == ($past(pinmap_reg) & {NUM_PINS{$past(ctrl_reg.all_com)}}))
        else $error("common role on unmapped pin or missing");

    AST_BAT: assert property (CE_IN && wr_b22 ##1 CE_IN |=>
        BAT_SUPPLY_OUT == $past(BUS_REQ_IN.wdata[`BATTERY_SUPPLY_SELECT_BIT], 2))
        else $error("battery select not routed");

    AST_NO_BLINK: assert property (CE_IN && blink23_reg == 6'h00 |=> !BLANK23_OUT)
        else $error("segment blanked with clear mask");

    AST_CONTRAST: assert property (CE_IN && wr_con ##1 CE_IN |=>
        CONTRAST_OUT == $past(BUS_REQ_IN.wdata[4:0], 2))
        else $error("contrast code not applied");

    AST_CTRL_RST: assert property (@(posedge CORE_CLK_IN) disable iff (1'b0)
        !RSTN_IN |=> ctrl_reg == ctrl_t'(8'h00))
        else $error("control register not zero after reset");

    AST_PULLUP: assert property (CE_IN |=>
        PIN_PULLUP_OUT == (~$past(pinmap_reg) & INPUT_ONLY))
        else $error("pull-up on wrong pins");

    AST_BLINK_FRAME: assert property ($changed(blink_reg) && ctrl_reg.enable |->
        $past(frame_end) && $past(frame_cnt_reg) == LAST_FRAME)
        else $error("blink toggled off a frame boundary");

    AST_FRAME_WRAP: assert property (s_frame_wrap |=> com_reg == 3'h0)
        else $error("common phase did not wrap at frame end");

    AST_PARK: assert property (s_disabled |=> com_reg == 3'h0 && blink_reg == BLINK_SHOW)
        else $error("common phase or blink not parked while disabled");

    AST_TICK_GATE: assert property (s_disabled |=> !FRAME_TICK_OUT)
        else $error("lcd clock pulse while disabled");

    AST_B22_CLEAR: assert property (CE_IN && blink22_reg == 6'h00 |=> !BLANK22_OUT)
        else $error("pin 22 blanked with clear mask");

    AST_LCD_EN: assert property (CE_IN |=> PIN_LCD_EN_OUT == $past(pinmap_reg))
        else $error("segment drive select does not follow pin map");

    AST_RDATA_IDLE: assert property (CE_IN && !BUS_REQ_IN.rd |=> RDATA_OUT == 8'h00)
        else $error("read data outside the cycle after a read");

    AST_CE_HOLD: assert property (!CE_IN |=>
        $stable(ctrl_reg) && $stable(com_reg) && $stable(blink_reg))
        else $error("state moved while clock enable low");

endmodule
`default_nettype wire

// file: include/lcd_cfg.svh
// offsets, field positions, reset values and timing counts of the lcd control block
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH

// register bus widths
`define LCD_ADDR_W 16
`define LCD_DATA_W 8

// register byte addresses
`define LCD_CTRL_ADDR     16'h2400
`define LCD_BLINK23_ADDR  16'h2401
`define LCD_BLINK22_ADDR  16'h2402
`define LCD_PINMAP_ADDR   16'h2405
`define LCD_CONTRAST_ADDR 16'h240d

// field positions
`define BATTERY_SUPPLY_SELECT_BIT      7
`define LCD_BLINK_MSB    5
`define LCD_CONTRAST_MSB 4

// reset values
`define LCD_CTRL_RST     8'h00
`define LCD_BLINK_RST    6'h00
`define LCD_PINMAP_RST   8'h00
`define LCD_CONTRAST_RST 5'h00

// core clock and crystal reference
`define LCD_CORE_PERIOD_NS 8
`define LCD_CORE_HZ        (1000000000 / `LCD_CORE_PERIOD_NS)
`define LCD_XTAL_HZ        32768
`define LCD_ACC_W          28
`define LCD_DIV_LOG2_MAX   9

// display geometry and blink pacing
`define LCD_NUM_PINS     8
`define LCD_NUM_COM      6
`define LCD_BLINK_FRAMES 32

`endif

// file: include/lcd_pkg.sv
// types shared by the lcd control block
`include "lcd_cfg.svh"

package lcd_pkg;

    // control register layout, msb first
    typedef struct packed {
        logic       enable;
        logic [2:0] mode;
        logic       all_com;
        logic       rsv;
        logic [1:0] clk_sel;
    } ctrl_t;

    // one register bus request
    typedef struct packed {
        logic [`LCD_ADDR_W-1:0] addr;
        logic [`LCD_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } bus_req_t;

    // blink phase of the selected segments
    typedef enum logic {BLINK_SHOW, BLINK_HIDE} blink_state_t;

endpackage

// file: tb/lcd_glass_model.sv
// passive glass model watching common drive and frame ticks
`timescale 1ns/1ps
`default_nettype none

module lcd_glass_model (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       frame_tick_in,
    input  wire logic [2:0] com_index_in,
    input  wire logic       bias_ground_in,
    output var  logic [7:0] tick_count_out,
    output var  logic [7:0] err_count_out
);
    logic bias_ground_reg;
    logic bad_phase;

    // a grounded panel sees no frames and a parked common
    assign bad_phase = bias_ground_reg && bias_ground_in
                       && (com_index_in != 3'h0 || frame_tick_in);

    // frame counting and common phase sanity
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            tick_count_out  <= 8'h00;
            err_count_out   <= 8'h00;
            bias_ground_reg <= 1'b0;
        end else begin
            bias_ground_reg <= bias_ground_in;
            if (frame_tick_in) begin
                tick_count_out <= tick_count_out + 8'h01;
            end
            if (com_index_in > 3'h5 || bad_phase) begin
                err_count_out <= err_count_out + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/segment_lcd_control_bench.sv
// self-checking bench for the segment lcd control block
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cfg.svh"

module segment_lcd_control_bench
    import lcd_pkg::*;
;
    // two core cycles per crystal period keep lcd clock waits short
    localparam int XTAL_CYC   = 2;
    localparam int CORE_HZ_TB = XTAL_CYC * `LCD_XTAL_HZ;
    localparam int BLINK_N    = 2;

    logic       core_clk;
    logic       rstn;
    logic       ce;
    bus_req_t   req;
    logic [7:0] rdata;
    logic       frame_tick;
    logic [2:0] com_index;
    logic       bias_ground;
    logic [7:0] pin_lcd_en;
    logic [7:0] pin_as_com;
    logic [7:0] pin_ground;
    logic [7:0] pin_pullup;
    logic       bat_supply;
    logic [4:0] contrast;
    logic [2:0] mode;
    logic       blank23;
    logic       blank22;
    logic [7:0] glass_ticks;
    logic [7:0] glass_err;
    int         n_fail;
    int         total_checks;
    logic [15:0] gap;
    logic [15:0] hlen;
    logic [7:0]  hbad;
    logic [2:0]  com_seen;

    segment_lcd_control #(.CORE_HZ(CORE_HZ_TB), .BLINK_FRAMES(BLINK_N)) i_dut (
        .CORE_CLK_IN(core_clk), .RSTN_IN(rstn), .CE_IN(ce), .BUS_REQ_IN(req),
        .RDATA_OUT(rdata), .FRAME_TICK_OUT(frame_tick), .COM_INDEX_OUT(com_index),
        .BIAS_GROUND_OUT(bias_ground), .PIN_LCD_EN_OUT(pin_lcd_en),
        .PIN_AS_COM_OUT(pin_as_com), .PIN_GROUND_OUT(pin_ground),
        .PIN_PULLUP_OUT(pin_pullup), .BAT_SUPPLY_OUT(bat_supply),
        .CONTRAST_OUT(contrast), .MODE_OUT(mode),
        .BLANK23_OUT(blank23), .BLANK22_OUT(blank22)
    );

    lcd_glass_model i_glass (
        .clk_in(core_clk), .rstn_in(rstn), .frame_tick_in(frame_tick),
        .com_index_in(com_index), .bias_ground_in(bias_ground),
        .tick_count_out(glass_ticks), .err_count_out(glass_err)
    );

    // 125 mhz core clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic summarize;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_cnt(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    // one bus cycle, launched just after an edge
    task automatic put(input logic [15:0] a, input logic [7:0] d, input logic w, input logic r);
        @(posedge core_clk);
        req <= '{a, d, w, r};
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        put(a, d, 1'b1, 1'b0);
        put(16'h0000, 8'h00, 1'b0, 1'b0);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        put(a, 8'h00, 1'b0, 1'b1);
        put(16'h0000, 8'h00, 1'b0, 1'b0);
        #1;
        chk("rdata", exp, rdata);
    endtask

    // let registered outputs follow a write
    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // cycles from one lcd clock pulse to the next, bounded
    task automatic tick_gap(output logic [15:0] n);
        int k;
        k = 0;
        n = 16'h0000;
        while (frame_tick !== 1'b1 && k < 4096) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        do begin
            @(posedge core_clk);
            #1;
            k++;
            n++;
        end while (frame_tick !== 1'b1 && k < 4096);
        if (k >= 4096) begin
            n_fail++;
            summarize();
        end
    endtask

    // one whole hidden blink phase of pin 23; pin 22 hidden only at common 0
    task automatic hide_len(output logic [15:0] n, output logic [7:0] bad);
        int k;
        k = 0;
        n = 16'h0000;
        bad = 8'h00;
        while (blank23 !== 1'b0 && k < 8192) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        while (blank23 !== 1'b1 && k < 8192) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        while (blank23 === 1'b1 && k < 8192) begin
            if (blank22 !== (com_index == 3'h0)) begin
                bad++;
            end
            @(posedge core_clk);
            #1;
            k++;
            n++;
        end
        if (k >= 8192) begin
            n_fail++;
            summarize();
        end
    endtask

    // hang guard
    initial begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        summarize();
    end

    // main sequence
    initial begin
        n_fail = 0;
        total_checks = 0;
        rstn = 1'b0;
        ce = 1'b1;
        req = '0;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        rd(`LCD_CTRL_ADDR, 8'h00);
        rd(`LCD_BLINK23_ADDR, 8'h00);
        rd(`LCD_BLINK22_ADDR, 8'h00);
        rd(`LCD_PINMAP_ADDR, 8'h00);
        rd(`LCD_CONTRAST_ADDR, 8'h00);
        chk("bias_ground", 8'h01, 8'(bias_ground));
        // disabled panel with mapped pins
        wr(`LCD_PINMAP_ADDR, 8'h35);
        settle();
        chk("pin_lcd_en", 8'h35, pin_lcd_en);
        chk("pin_ground", 8'h35, pin_ground);
        chk("pin_pullup", 8'hc0, pin_pullup);
        chk("pin_as_com", 8'h00, pin_as_com);
        wr(`LCD_CTRL_ADDR, 8'h08);
        settle();
        chk("pin_as_com", 8'h35, pin_as_com);
        // blink masks and battery select
        wr(`LCD_BLINK23_ADDR, 8'hff);
        wr(`LCD_BLINK22_ADDR, 8'hff);
        rd(`LCD_BLINK23_ADDR, 8'h3f);
        rd(`LCD_BLINK22_ADDR, 8'hbf);
        settle();
        chk("bat_supply", 8'h01, 8'(bat_supply));
        chk("blank23", 8'h00, 8'(blank23));
        chk("blank22", 8'h00, 8'(blank22));
        wr(`LCD_BLINK22_ADDR, 8'h01);
        settle();
        chk("bat_supply", 8'h00, 8'(bat_supply));
        // contrast code at its top value and at 1
        wr(`LCD_CONTRAST_ADDR, 8'hff);
        rd(`LCD_CONTRAST_ADDR, 8'h1f);
        settle();
        chk("contrast", 8'h1f, 8'(contrast));
        wr(`LCD_CONTRAST_ADDR, 8'he1);
        settle();
        chk("contrast", 8'h01, 8'(contrast));
        // unmapped places
        wr(16'h2403, 8'hff);
        rd(16'h2403, 8'h00);
        rd(16'h2406, 8'h00);
        rd(`LCD_CTRL_ADDR, 8'h08);
        // write then read back to back, enabling the panel
        put(`LCD_CTRL_ADDR, 8'hff, 1'b1, 1'b0);
        put(`LCD_CTRL_ADDR, 8'h00, 1'b0, 1'b1);
        put(16'h0000, 8'h00, 1'b0, 1'b0);
        #1;
        chk("rdata", 8'hfb, rdata);
        @(posedge core_clk);
        #1;
        chk("rdata", 8'h00, rdata);
        settle();
        chk("mode", 8'h07, 8'(mode));
        chk("bias_ground", 8'h00, 8'(bias_ground));
        chk("pin_ground", 8'h00, pin_ground);
        chk("pin_as_com", 8'h35, pin_as_com);
        // clock enable low takes nothing
        @(posedge core_clk);
        ce <= 1'b0;
        wr(`LCD_CTRL_ADDR, 8'h00);
        @(posedge core_clk);
        ce <= 1'b1;
        rd(`LCD_CTRL_ADDR, 8'hfb);
        // lcd clock spacing, common stepping and one blink phase
        tick_gap(gap);
        chk_cnt("tick_gap_sel3", 16'(64 * XTAL_CYC), gap);
        @(posedge core_clk);
        #1;
        com_seen = com_index;
        tick_gap(gap);
        chk_cnt("tick_gap_sel3", 16'(64 * XTAL_CYC), gap);
        @(posedge core_clk);
        #1;
        chk("com_step", 8'((32'(com_seen) + 2) % `LCD_NUM_COM), 8'(com_index));
        hide_len(hlen, hbad);
        chk_cnt("hide_len", 16'(BLINK_N * `LCD_NUM_COM * 64 * XTAL_CYC), hlen);
        chk("blank22_com", 8'h00, hbad);
        wr(`LCD_CTRL_ADDR, 8'hf8);
        settle();
        tick_gap(gap);
        chk_cnt("tick_gap_sel0", 16'(512 * XTAL_CYC), gap);
        // disable again: grounding returns, commons park
        wr(`LCD_CTRL_ADDR, 8'h03);
        settle();
        repeat (20) @(posedge core_clk);
        #1;
        chk("bias_ground", 8'h01, 8'(bias_ground));
        chk("pin_ground", 8'h35, pin_ground);
        chk("com_index", 8'h00, 8'(com_index));
        chk("blank23", 8'h00, 8'(blank23));
        chk("glass_err", 8'h00, glass_err);
        // second reset clears the control, pin map and pin 23 blink fields
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        rd(`LCD_CTRL_ADDR, 8'h00);
        rd(`LCD_PINMAP_ADDR, 8'h00);
        rd(`LCD_BLINK23_ADDR, 8'h00);
        chk("frame_ticks", 8'h00, glass_ticks);
        summarize();
    end
endmodule
`default_nettype wire
